// ==== logic/calf_consts.svh ====
// Constants for the CAN acceptance lookup filter
`ifndef CALF_CONSTS_SVH
`define CALF_CONSTS_SVH
// ==========================================
// Register byte addresses (APB)
`define CALF_A_MODE    12'h000
`define CALF_A_SSTD    12'h004
`define CALF_A_SGRP    12'h008
`define CALF_A_SEXT    12'h00c
`define CALF_A_EGRP    12'h010
`define CALF_A_EOT     12'h014
`define CALF_A_LUSTAT  12'h018
`define CALF_A_MEM     12'h800
// ==========================================
// Mode register fields
`define CALF_B_DSE     1
`define CALF_B_BYP     0
// ==========================================
// Entry word fields
`define CALF_E_CTL_HI  31
`define CALF_E_CTL_LO  29
`define CALF_E_DIS     28
`define CALF_E_ID_HI   26
`define CALF_E_ID_LO   16
`define CALF_HALF      16
// ==========================================
// Object header fields
`define CALF_H_FF      31
`define CALF_H_RTR     30
`define CALF_H_SEM_HI  25
`define CALF_H_SEM_LO  24
`define CALF_H_LEN_HI  22
`define CALF_H_LEN_LO  16
`define CALF_H_ID_HI   10
`define CALF_SEM_BUSY  2'h1
`define CALF_SEM_DONE  2'h3
`define CALF_SEM_READ  2'h0
`define CALF_OBJ_WORDS 3
`endif

// ==== logic/calf_pkg.sv ====
// Types for the CAN acceptance lookup filter
package calf_pkg;
  // Search state machine, Gray coded along the main path
  typedef enum logic [2:0] {
    CALF_IDLE = 3'h0,
    CALF_READ = 3'h1,
    CALF_CMP  = 3'h3,
    CALF_HDR  = 3'h2,
    CALF_D1   = 3'h6,
    CALF_D2   = 3'h7,
    CALF_SEMD = 3'h5,
    CALF_DONE = 3'h4
  } calf_state_e;
endpackage : calf_pkg

// ==== logic/calf_lookup_ram.sv ====
// Word-wide lookup memory with one CPU port and one filter port
`timescale 1ns/1ns
`default_nettype none
module calf_lookup_ram #(
  parameter int DEPTH = 512,
  parameter int AW    = 9
) (
  // Clock
  input  wire logic          pclk,
  // Port A: CPU
  input  wire logic          a_we,
  input  wire logic [AW-1:0] a_addr,
  input  wire logic [31:0]   a_wdata,
  output logic      [31:0]   a_rdata,
  // Port B: filter engine
  input  wire logic          b_we,
  input  wire logic [AW-1:0] b_addr,
  input  wire logic [31:0]   b_wdata,
  output logic      [31:0]   b_rdata
);
  if (DEPTH > (1 << AW)) begin : g_depth_chk
    $error("calf_lookup_ram: DEPTH exceeds address width");
  end
  logic [31:0] mem [DEPTH];
  // ==========================================
  // Storage: filter write wins on a collision
  always_ff @(posedge pclk) begin
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end else if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end
endmodule : calf_lookup_ram
`default_nettype wire

// ==== logic/calf_entry_match.sv ====
// Compares one standard entry half-word against a received frame
`timescale 1ns/1ns
`default_nettype none
module calf_entry_match (
  // Entry half placed in the upper half-word layout
  input  wire logic [15:0] entry,
  // Received frame
  input  wire logic [2:0]  rx_ctl,
  input  wire logic [10:0] rx_id,
  // Result
  output logic             hit,
  output logic             above
);
  logic [13:0] key_e;
  logic [13:0] key_r;
  // Controller number then identifier forms the sort key
  always_comb begin
    key_e = {entry[15:13], entry[10:0]};
    key_r = {rx_ctl, rx_id};
    hit   = (key_e == key_r) && !entry[12];
    above = key_e > key_r;
  end
endmodule : calf_entry_match
`default_nettype wire

// ==== logic/calf_filter.sv ====
// CAN acceptance lookup filter: lookup memory, search and direct store
`timescale 1ns/1ns
`default_nettype none
`include "calf_consts.svh"
// Contract
// - 512-word memory, 1024 standard or 512 extended
// - Memory accepts only full word accesses
// - Five sections in fixed order
// - Start offsets relative; direct section at zero
// - Message objects start at end-of-table offset
// - Equal consecutive offsets mean absent section
// - Direct section searched only when enabled
// - Entry word field decoding
// - Disable flag zero enabled, one disabled
// - Direct section first, then following sections; code searches only the explicit standard section after it
// - Direct match copies frame into object
// - Object at offset plus twelve times index
// - Header word field layout
// - Semaphore encoding 01 busy, 11 done, 00
// - Semaphore 01 before data, 11 after
// - Bypass accepts all and flags it
module calf_filter #(
  parameter int DEPTH = 512,
  parameter int AW    = 9
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [3:0]    pstrb,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Received frame from a controller
  input  wire logic          rx_valid,
  input  wire logic [2:0]    rx_ctl,
  input  wire logic          rx_ext,
  input  wire logic          rx_rtr,
  input  wire logic [6:0]    rx_len,
  input  wire logic [10:0]   rx_id,
  input  wire logic [63:0]   rx_data,
  output logic               rx_ready,
  // Result to the controller
  output logic               rx_done,
  output logic               rx_accept,
  output logic               rx_bypass,
  output logic               rx_stored,
  output logic [9:0]         rx_index
);
  import calf_pkg::*;
  if (DEPTH != 512 || AW != 9) begin : g_depth_chk
    $error("calf_filter: memory must be 512 words");
  end
  // ==========================================
  // Registers
  logic [1:0]    mode_reg, mode_next;
  logic [AW+1:0] sstd_reg, sstd_next;
  logic [AW+1:0] sgrp_reg, sgrp_next;
  logic [AW+1:0] sext_reg, sext_next;
  logic [AW+1:0] egrp_reg, egrp_next;
  logic [AW+1:0] eot_reg,  eot_next;
  logic [31:0]   prdata_reg, prdata_next;
  logic          ack_reg, ack_next;
  logic          err_reg, err_next;
  logic          mrd_reg, mrd_next;
  calf_state_e   st_reg, st_next;
  logic [AW-1:0] ptr_reg, ptr_next;
  logic [9:0]    idx_reg, idx_next;
  logic          acc_reg, acc_next;
  logic          byp_reg, byp_next;
  logic          sto_reg, sto_next;
  logic [9:0]    ridx_reg, ridx_next;
  logic [AW-1:0] obj_reg, obj_next;
  // Memory ports
  logic          a_we;
  logic [31:0]   a_rdata;
  logic          b_we;
  logic [AW-1:0] b_addr;
  logic [31:0]   b_wdata;
  logic [31:0]   b_rdata;
  logic          hit_e, hit_o, abv_e, abv_o;
  logic          in_mem, setup, access, reg_hit;
  // Byte offset to word index
  function automatic logic [AW-1:0] word_of(input logic [AW+1:0] off);
    return off[AW+1:2];
  endfunction : word_of
  // ==========================================
  // Memory and entry comparators
  calf_lookup_ram #(.DEPTH(DEPTH), .AW(AW)) u_ram (
    .pclk    (pclk),
    .a_we    (a_we),
    .a_addr  (paddr[AW+1:2]),
    .a_wdata (pwdata),
    .a_rdata (a_rdata),
    .b_we    (b_we),
    .b_addr  (b_addr),
    .b_wdata (b_wdata),
    .b_rdata (b_rdata)
  );
  calf_entry_match u_even (
    .entry  (b_rdata[31:16]),
    .rx_ctl (rx_ctl),
    .rx_id  (rx_id),
    .hit    (hit_e),
    .above  (abv_e)
  );
  calf_entry_match u_odd (
    .entry  (b_rdata[15:0]),
    .rx_ctl (rx_ctl),
    .rx_id  (rx_id),
    .hit    (hit_o),
    .above  (abv_o)
  );
  // ==========================================
  // APB decode: memory lies in the upper 2 kB
  always_comb begin
    in_mem  = paddr >= `CALF_A_MEM;
    setup   = psel && !penable;
    access  = psel && penable && ack_reg;
    reg_hit = (paddr <= `CALF_A_LUSTAT) && (paddr[1:0] == 2'h0);
    // partial strobes refused on memory writes
    a_we    = access && pwrite && in_mem && (pstrb == 4'hf) && (st_reg == CALF_IDLE);
  end
  // Register and answer next values
  always_comb begin
    mode_next   = mode_reg;
    sstd_next   = sstd_reg;
    sgrp_next   = sgrp_reg;
    sext_next   = sext_reg;
    egrp_next   = egrp_reg;
    eot_next    = eot_reg;
    prdata_next = prdata_reg;
    err_next    = 1'b0;
    // Answer one cycle after setup; memory read needs that cycle
    ack_next    = setup;
    if (access) begin
      err_next = 1'b0;
    end
    if (setup) begin
      err_next = (!in_mem && !reg_hit) || (in_mem && pwrite && (pstrb != 4'hf))
                 || (in_mem && pwrite && (st_reg != CALF_IDLE));
    end
    if (access && pwrite && !err_reg && !in_mem) begin
      case (paddr)
        `CALF_A_MODE: mode_next = pwdata[1:0];
        `CALF_A_SSTD: sstd_next = {pwdata[AW+1:2], 2'h0};
        `CALF_A_SGRP: sgrp_next = {pwdata[AW+1:2], 2'h0};
        `CALF_A_SEXT: sext_next = {pwdata[AW+1:2], 2'h0};
        `CALF_A_EGRP: egrp_next = {pwdata[AW+1:2], 2'h0};
        `CALF_A_EOT:  eot_next  = {pwdata[AW+1:2], 2'h0};
        default:      mode_next = mode_reg;
      endcase
    end
    // Memory read data is shown straight from the memory output register
    mrd_next    = setup && in_mem && !pwrite;
    // Register read data is latched at setup so it stands in the access cycle
    if (setup && !pwrite) begin
      prdata_next = 32'h0;
      if (!in_mem) begin
        case (paddr)
          `CALF_A_MODE:   prdata_next = {30'h0, mode_reg};
          `CALF_A_SSTD:   prdata_next = {21'h0, sstd_reg};
          `CALF_A_SGRP:   prdata_next = {21'h0, sgrp_reg};
          `CALF_A_SEXT:   prdata_next = {21'h0, sext_reg};
          `CALF_A_EGRP:   prdata_next = {21'h0, egrp_reg};
          `CALF_A_EOT:    prdata_next = {21'h0, eot_reg};
          `CALF_A_LUSTAT: prdata_next = {16'h0, st_reg, acc_reg, byp_reg, sto_reg, ridx_reg};
          default:        prdata_next = 32'h0;
        endcase
      end
    end
  end
  always_comb begin
    pready  = ack_reg;
    pslverr = ack_reg && err_reg;
    prdata  = mrd_reg ? a_rdata : prdata_reg;
  end
  // ==========================================
  // Search engine next values
  always_comb begin
    st_next   = st_reg;
    ptr_next  = ptr_reg;
    idx_next  = idx_reg;
    acc_next  = acc_reg;
    byp_next  = byp_reg;
    sto_next  = sto_reg;
    ridx_next = ridx_reg;
    obj_next  = obj_reg;
    b_we      = 1'b0;
    b_addr    = ptr_reg;
    b_wdata   = 32'h0;
    case (st_reg)
      CALF_IDLE: begin
        if (rx_valid) begin
          acc_next = 1'b0;
          sto_next = 1'b0;
          byp_next = 1'b0;
          idx_next = 10'h0;
          if (mode_reg[`CALF_B_BYP]) begin
            acc_next = 1'b1;
            byp_next = 1'b1;
            st_next  = CALF_DONE;
          end else if (rx_ext) begin
            // Extended frames are not searched; they end unaccepted
            st_next = CALF_DONE;
          end else if (mode_reg[`CALF_B_DSE] && (sstd_reg != '0)) begin
            ptr_next = '0;
            st_next  = CALF_READ;
          end else if (sgrp_reg != sstd_reg) begin
            ptr_next = word_of(sstd_reg);
            st_next  = CALF_READ;
          end else begin
            st_next = CALF_DONE;
          end
        end
      end
      CALF_READ: begin
        st_next = CALF_CMP;
      end
      CALF_CMP: begin
        // direct section occupies [0, sstd), explicit [sstd, sgrp)
        if (hit_e || hit_o) begin
          acc_next  = 1'b1;
          ridx_next = idx_reg + {9'h0, hit_o};
          if (ptr_reg < word_of(sstd_reg) && mode_reg[`CALF_B_DSE]) begin
            sto_next = 1'b1;
            // byte offset eot + 12*i, as a word index eot/4 + 3*i
            obj_next = word_of(eot_reg) + 9'((idx_reg + {9'h0, hit_o}) * 10'd3);
            st_next  = CALF_HDR;
          end else begin
            st_next = CALF_DONE;
          end
        end else if (abv_e || abv_o) begin
          // Sorted table: passed the key, leave this section
          if (ptr_reg < word_of(sstd_reg) && (sgrp_reg != sstd_reg)) begin
            ptr_next = word_of(sstd_reg);
            idx_next = {ptr_next, 1'b0};
            st_next  = CALF_READ;
          end else begin
            st_next = CALF_DONE;
          end
        end else if (9'(ptr_reg + 9'h1) == word_of(sstd_reg) && mode_reg[`CALF_B_DSE]
                     && ptr_reg < word_of(sstd_reg)) begin
          ptr_next = word_of(sstd_reg);
          idx_next = {ptr_next, 1'b0};
          st_next  = (sgrp_reg != sstd_reg) ? CALF_READ : CALF_DONE;
        end else if (9'(ptr_reg + 9'h1) >= word_of(sgrp_reg)) begin
          st_next = CALF_DONE;
        end else begin
          ptr_next = ptr_reg + 9'h1;
          idx_next = idx_reg + 10'h2;
          st_next  = CALF_READ;
        end
      end
      CALF_HDR: begin
        // Header first, marking the object busy
        b_we    = 1'b1;
        b_addr  = obj_reg;
        b_wdata = 32'h0;
        b_wdata[`CALF_H_FF]  = rx_ext;
        b_wdata[`CALF_H_RTR] = rx_rtr;
        b_wdata[`CALF_H_SEM_HI:`CALF_H_SEM_LO] = `CALF_SEM_BUSY;
        b_wdata[`CALF_H_LEN_HI:`CALF_H_LEN_LO] = rx_len;
        b_wdata[`CALF_H_ID_HI:0] = rx_id;
        st_next = CALF_D1;
      end
      CALF_D1: begin
        b_we    = 1'b1;
        b_addr  = obj_reg + 9'h1;
        b_wdata = rx_data[31:0];
        st_next = CALF_D2;
      end
      CALF_D2: begin
        b_we    = 1'b1;
        b_addr  = obj_reg + 9'h2;
        b_wdata = rx_data[63:32];
        st_next = CALF_SEMD;
      end
      CALF_SEMD: begin
        // Rewrite header with the finished semaphore
        b_we    = 1'b1;
        b_addr  = obj_reg;
        b_wdata = 32'h0;
        b_wdata[`CALF_H_FF]  = rx_ext;
        b_wdata[`CALF_H_RTR] = rx_rtr;
        b_wdata[`CALF_H_SEM_HI:`CALF_H_SEM_LO] = `CALF_SEM_DONE;
        b_wdata[`CALF_H_LEN_HI:`CALF_H_LEN_LO] = rx_len;
        b_wdata[`CALF_H_ID_HI:0] = rx_id;
        st_next = CALF_DONE;
      end
      CALF_DONE: begin
        st_next = CALF_IDLE;
      end
      default: begin
        st_next = CALF_IDLE;
      end
    endcase
  end
  always_comb begin
    rx_ready  = (st_reg == CALF_DONE);
    rx_done   = (st_reg == CALF_DONE);
    rx_accept = acc_reg;
    rx_bypass = byp_reg;
    rx_stored = sto_reg;
    rx_index  = ridx_reg;
  end
  // ==========================================
  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg   <= 2'h0;
      sstd_reg   <= '0;
      sgrp_reg   <= '0;
      sext_reg   <= '0;
      egrp_reg   <= '0;
      eot_reg    <= '0;
      prdata_reg <= 32'h0;
      ack_reg    <= 1'b0;
      err_reg    <= 1'b0;
      mrd_reg    <= 1'b0;
      st_reg     <= CALF_IDLE;
      ptr_reg    <= '0;
      idx_reg    <= 10'h0;
      acc_reg    <= 1'b0;
      byp_reg    <= 1'b0;
      sto_reg    <= 1'b0;
      ridx_reg   <= 10'h0;
      obj_reg    <= '0;
    end else begin
      mode_reg   <= mode_next;
      sstd_reg   <= sstd_next;
      sgrp_reg   <= sgrp_next;
      sext_reg   <= sext_next;
      egrp_reg   <= egrp_next;
      eot_reg    <= eot_next;
      prdata_reg <= prdata_next;
      ack_reg    <= ack_next;
      err_reg    <= err_next;
      mrd_reg    <= mrd_next;
      st_reg     <= st_next;
      ptr_reg    <= ptr_next;
      idx_reg    <= idx_next;
      acc_reg    <= acc_next;
      byp_reg    <= byp_next;
      sto_reg    <= sto_next;
      ridx_reg   <= ridx_next;
      obj_reg    <= obj_next;
    end
  end
endmodule : calf_filter
`default_nettype wire

// ==== dv/calf_filter_properties.sv ====
// Port checks for the acceptance lookup filter
`timescale 1ns/1ns
`default_nettype none
module calf_filter_properties (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  // Frame
  input wire logic        rx_valid,
  input wire logic        rx_ext,
  input wire logic        rx_ready,
  input wire logic        rx_done,
  input wire logic        rx_accept,
  input wire logic        rx_bypass,
  input wire logic        rx_stored
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // APB answer checks and frame steps
  sequence s_take; $rose(rx_valid); endsequence
  sequence s_end; ##[1:1000] rx_done; endsequence
  property p_ready; psel && penable |-> pready; endproperty
  property p_part;
    psel && penable && pwrite && paddr[11] && pstrb != 4'hf |-> pslverr;
  endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_pair; rx_ready |-> rx_done ##1 !rx_done; endproperty
  property p_answer; s_take |-> s_end; endproperty
  property p_byp; rx_done && rx_bypass |-> rx_accept && !rx_stored; endproperty
  property p_store; rx_done && rx_stored |-> rx_accept && $past(rx_valid, 6); endproperty
  property p_ext; rx_done && rx_ext && !rx_bypass |-> !rx_accept; endproperty
  property p_held; !rx_valid |=> $stable({rx_accept, rx_bypass, rx_stored}); endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  a_part: assert property (p_part) else $error("partial write taken");
  a_err: assert property (p_err) else $error("error without ready");
  a_pair: assert property (p_pair) else $error("done not paired");
  a_answer: assert property (p_answer) else $error("frame not answered");
  a_byp: assert property (p_byp) else $error("bypass result wrong");
  a_store: assert property (p_store) else $error("store too short");
  a_ext: assert property (p_ext) else $error("extended accepted");
  a_held: assert property (p_held) else $error("result not held");
endmodule : calf_filter_properties
`default_nettype wire

// ==== dv/calf_rx_source.sv ====
// Controller receive path offering frames to the filter
`timescale 1ns/1ns
`default_nettype none
module calf_rx_source (
  // Clock
  input wire logic         pclk,
  // Frame offered
  output logic             rx_valid,
  output logic [2:0]       rx_ctl,
  output logic             rx_ext,
  output logic             rx_rtr,
  output logic [6:0]       rx_len,
  output logic [10:0]      rx_id,
  output logic [63:0]      rx_data,
  input wire logic         rx_ready
);
  // Idle at time zero
  initial begin
    rx_valid = 1'b0;
    {rx_ctl, rx_ext, rx_rtr, rx_len, rx_id, rx_data} = '0;
  end
  // Offer after a gap, hold until taken, then scramble the lines
  task automatic send(input logic [86:0] f, input int g);
    repeat (g + 1) @(posedge pclk);
    rx_valid <= 1'b1;
    {rx_ctl, rx_ext, rx_rtr, rx_len, rx_id, rx_data} <= f;
    @(posedge pclk);
    while (rx_ready !== 1'b1) @(posedge pclk);
    rx_valid <= 1'b0;
    {rx_ctl, rx_ext, rx_rtr, rx_len, rx_id, rx_data} <= ~f;
  endtask : send
endmodule : calf_rx_source
`default_nettype wire

// ==== dv/can_acceptance_lookup_filter_tb_top.sv ====
// Self-checking bench for the acceptance lookup filter
`timescale 1ns/1ns
`default_nettype none
`include "calf_consts.svh"
module can_acceptance_lookup_filter_tb_top;
  localparam logic [63:0] D = 64'h8877_6655_4433_2211;
  localparam logic [11:0] M = `CALF_A_MEM;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata;
  logic        rx_valid, rx_ext, rx_rtr, rx_ready, rx_done;
  logic        rx_accept, rx_bypass, rx_stored;
  logic [2:0]  rx_ctl;
  logic [6:0]  rx_len;
  logic [10:0] rx_id;
  logic [63:0] rx_data;
  logic [9:0]  rx_index;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cycles = 0;
  calf_filter calf_filter_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pstrb, .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_ctl, .rx_ext,
    .rx_rtr, .rx_len, .rx_id, .rx_data, .rx_ready, .rx_done, .rx_accept,
    .rx_bypass, .rx_stored, .rx_index);
  calf_rx_source calf_rx_source_inst (.pclk, .rx_valid, .rx_ctl, .rx_ext,
    .rx_rtr, .rx_len, .rx_id, .rx_data, .rx_ready);
  // Clock
  always #20 pclk = ~pclk;
  // Hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, 4'hf, r, e);
    chk({31'h0, e}, 32'h0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, 4'h0, r, e);
    chk(r, x);
  endtask : rd
  task automatic frm(input logic [2:0] c, input logic x, input logic [10:0] id,
                     input int g, input logic [2:0] f);
    calf_rx_source_inst.send({c, x, 1'b1, 7'h08, id, D}, g);
    chk({29'h0, rx_accept, rx_bypass, rx_stored}, {29'h0, f});
  endtask : frm
  // ==========================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    rd(`CALF_A_MODE, 32'h0);
    apb(1'b0, 12'h01c, 32'h0, 4'h0, r, e);
    chk({31'h0, e}, 32'h1);
    wr(12'hffc, 32'h5a5a_a5a5);
    apb(1'b1, 12'hffc, 32'h0, 4'h3, r, e);
    chk({31'h0, e}, 32'h1);
    rd(12'hffc, 32'h5a5a_a5a5);
  endtask : t_regs
  task automatic t_direct;
    logic [31:0] cfg [5] = '{32'h8, 32'hc, 32'hc, 32'hc, 32'hc};
    wr(M, 32'h0100_1200);
    wr(M + 12'h4, 32'h0300_0400);
    wr(M + 12'h8, 32'h17ff_4555);
    for (int i = 0; i < 5; i++) wr(12'(4 * i + 4), cfg[i]);
    wr(`CALF_A_MODE, 32'h2);
    frm(3'h0, 1'b0, 11'h400, 0, 3'b101);
    chk({22'h0, rx_index}, 32'h3);
    rd(M + 12'h030, 32'h4308_0400);
    rd(M + 12'h034, 32'h4433_2211);
    rd(M + 12'h038, 32'h8877_6655);
    wr(M + 12'h030, 32'h4008_0400);
    rd(M + 12'h030, 32'h4008_0400);
    frm(3'h0, 1'b0, 11'h400, 5, 3'b101);
    rd(M + 12'h030, 32'h4308_0400);
    frm(3'h0, 1'b0, 11'h200, 0, 3'b000);
    frm(3'h1, 1'b0, 11'h100, 0, 3'b000);
    frm(3'h0, 1'b0, 11'h100, 0, 3'b101);
    rd(M + 12'h00c, 32'h4308_0100);
    frm(3'h2, 1'b0, 11'h555, 0, 3'b100);
    frm(3'h0, 1'b0, 11'h7ff, 0, 3'b000);
    frm(3'h0, 1'b1, 11'h400, 0, 3'b000);
  endtask : t_direct
  task automatic t_off;
    wr(`CALF_A_MODE, 32'h0);
    frm(3'h0, 1'b0, 11'h400, 0, 3'b000);
    frm(3'h2, 1'b0, 11'h555, 2, 3'b100);
    wr(`CALF_A_SGRP, 32'h8);
    frm(3'h2, 1'b0, 11'h555, 0, 3'b000);
  endtask : t_off
  task automatic t_bypass;
    wr(`CALF_A_MODE, 32'h1);
    frm(3'h5, 1'b0, 11'h123, 0, 3'b110);
    frm(3'h5, 1'b1, 11'h7ff, 0, 3'b110);
  endtask : t_bypass
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pstrb, pwdata} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_direct();
    t_off();
    t_bypass();
    end_of_test();
  end
endmodule : can_acceptance_lookup_filter_tb_top
bind calf_filter calf_filter_properties calf_filter_properties_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pstrb, .pready, .pslverr, .rx_valid,
  .rx_ext, .rx_ready, .rx_done, .rx_accept, .rx_bypass, .rx_stored);
`default_nettype wire
